// [rtl/drive_param_pkg.sv]
// constants for the drive parameter object bank
package drive_param_pkg;
	// ========================================
	// object indices
	localparam logic [15:0] IDX_HW_CONFIG = 16'h4013;
	localparam logic [15:0] IDX_OPER_COND = 16'h4014;
	localparam logic [15:0] IDX_SPECIAL_MODE = 16'h4015;
	localparam logic [15:0] IDX_FACTORY = 16'h4016;
	localparam logic [15:0] IDX_BALLAST = 16'h4021;
	localparam logic [15:0] IDX_SERIAL = 16'h4040;
	localparam logic [15:0] IDX_DEVICE_IDENTIFIER = 16'h4041;
	localparam logic [15:0] IDX_BOOT_INFO = 16'h4042;
	// ========================================
	// subindices
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_1 = 8'h01;
	localparam logic [7:0] SUB_2 = 8'h02;
	localparam logic [7:0] SUB_3 = 8'h03;
	localparam logic [7:0] SUB_4 = 8'h04;
	localparam logic [7:0] SUB_5 = 8'h05;
	// ========================================
	// entry counts
	localparam logic [7:0] CNT_HW_CONFIG = 8'h01;
	localparam logic [7:0] CNT_OPER_COND = 8'h05;
	localparam logic [7:0] CNT_SPECIAL_MODE = 8'h02;
	localparam logic [7:0] CNT_FACTORY = 8'h01;
	localparam logic [7:0] CNT_BALLAST = 8'h03;
	localparam logic [7:0] CNT_BOOT_INFO = 8'h03;
	// ========================================
	// special drive mode source codes
	localparam logic [7:0] SDM_OFF = 8'h00;
	localparam logic [7:0] SDM_SWITCHES = 8'h01;
	localparam logic [7:0] SDM_VIRTUAL = 8'h02;
	// ========================================
	// reset values and fields
	localparam logic [31:0] HW_CONFIG_RESET = 32'h00000000;
	localparam logic [7:0] SDM_CFG_RESET = 8'h01;
	localparam logic [7:0] SDM_VIRT_RESET = 8'h00;
	localparam logic [31:0] BAL_SETTINGS_RESET = 32'h00000001;
	localparam logic [31:0] BAL_LIMIT_RESET = 32'h0000D867;
	localparam logic [31:0] BAL_HYST_RESET = 32'h000001F4;
	localparam int BAL_ON_BIT = 0;
	localparam int BOOT_MAJOR_LSB = 16;
endpackage

// [rtl/ballast_switch.sv]
// ballast on/off comparator with hysteresis
`timescale 1ns/1ps
module ballast_switch (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic signed [31:0] i_supply_mv,
	input wire logic [31:0] i_limit_mv,
	input wire logic [31:0] i_hyst_mv,
	output logic o_active
);
	logic active_reg;
	logic active_next;
	logic signed [33:0] supply_ext;
	logic signed [33:0] on_level;
	logic signed [33:0] off_level;

	// ========================================
	// threshold compare
	always_comb begin
		supply_ext = 34'(i_supply_mv);
		on_level = $signed({2'b00, i_limit_mv});
		off_level = on_level - $signed({2'b00, i_hyst_mv});
		active_next = active_reg;
		if (!i_enable) begin
			active_next = 1'b0; // R5
		end else if (supply_ext > on_level) begin
			active_next = 1'b1; // R6 R12
		end else if (supply_ext < off_level) begin
			active_next = 1'b0; // R7 R12
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	assign o_active = active_reg;

	// ========================================
	// checks
	a_ballast_switch_on: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R6
		i_enable && (supply_ext > on_level) |=> o_active)
		else $error("ballast did not switch on above threshold");
	a_ballast_switch_off: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R12
		i_enable && (supply_ext < off_level) |=> !o_active)
		else $error("ballast did not switch off below hysteresis band");
	a_ballast_band_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R7
		i_enable && (supply_ext <= on_level) && (supply_ext >= off_level)
		|=> o_active == $past(o_active))
		else $error("ballast changed inside hysteresis band");
	a_ballast_disabled_off: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R5
		!i_enable |=> !o_active)
		else $error("ballast active while disabled");
	c_ballast_cycle: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		$rose(o_active) ##[1:1000] $fell(o_active));
endmodule

// [rtl/drive_parameter_objects.sv]
// drive parameter object bank behind the object dictionary port
`timescale 1ns/1ps
// Contract
// R1: configuration zero turns all special drive modes off.
// R2: configuration one enables special modes, mode from external switches.
// R3: configuration two enables special modes, mode from virtual switch entry.
// R4: factory auto-setup flag reads 1 if run in production, else 0; read-only.
// R5: ballast settings bit 0 turns ballast on/off; resets to one.
// R6: supply voltage limit in mV is the ballast switching threshold.
// R7: hysteresis in mV applies to threshold; resets to preset 0x1F4.
// R8: supply voltage reads as signed 32-bit millivolts, read-only.
// R9: logic voltage reads as signed 32-bit millivolts, read-only.
// R10: board temperature reads as signed 32-bit tenths of a degree.
// R11: bootloader version holds major in upper half, minor in lower half.
// R12: ballast on above threshold, off only below threshold minus hysteresis.
module drive_parameter_objects (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_obj_req,
	input wire logic i_obj_write,
	input wire logic [15:0] i_obj_index,
	input wire logic [7:0] i_obj_subindex,
	input wire logic [31:0] i_obj_wdata,
	output logic o_obj_ack,
	output logic o_obj_error,
	output logic [31:0] o_obj_rdata,
	input wire logic signed [31:0] i_power_supply_voltage,
	input wire logic signed [31:0] i_logic_supply_voltage,
	input wire logic signed [31:0] i_board_temperature,
	input wire logic [7:0] i_config_switches,
	input wire logic i_autosetup_done,
	input wire logic [31:0] i_serial_text,
	input wire logic [31:0] i_device_identifier,
	input wire logic [15:0] i_boot_major,
	input wire logic [15:0] i_boot_minor,
	input wire logic [31:0] i_boot_fieldbus,
	input wire logic [31:0] i_boot_hw_group,
	output logic o_special_enable,
	output logic [7:0] o_special_mode,
	output logic [31:0] o_hw_config,
	output logic o_ballast_on
);
	import drive_param_pkg::*;

	logic [31:0] hw_cfg_reg, hw_cfg_next;
	logic [7:0] sdm_cfg_reg, sdm_cfg_next;
	logic [7:0] sdm_virt_reg, sdm_virt_next;
	logic [31:0] bal_set_reg, bal_set_next;
	logic [31:0] bal_lim_reg, bal_lim_next;
	logic [31:0] bal_hyst_reg, bal_hyst_next;
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	logic spen_reg, spen_next;
	logic [7:0] spmode_reg, spmode_next;
	logic [31:0] rd_value;
	logic hit;
	logic writable;

	// ========================================
	// object decode
	always_comb begin
		rd_value = 32'h00000000;
		hit = 1'b1;
		writable = 1'b0;
		unique case (i_obj_index)
			IDX_HW_CONFIG: begin
				if (i_obj_subindex == SUB_COUNT) rd_value = {24'h000000, CNT_HW_CONFIG};
				else if (i_obj_subindex == SUB_1) begin
					rd_value = hw_cfg_reg;
					writable = 1'b1;
				end else hit = 1'b0;
			end
			IDX_OPER_COND: begin
				unique case (i_obj_subindex)
					SUB_COUNT: rd_value = {24'h000000, CNT_OPER_COND};
					SUB_1: rd_value = i_power_supply_voltage; // R8
					SUB_2: rd_value = i_logic_supply_voltage; // R9
					SUB_3: rd_value = i_board_temperature; // R10
					SUB_4, SUB_5: rd_value = 32'h00000000;
					default: hit = 1'b0;
				endcase
			end
			IDX_SPECIAL_MODE: begin
				unique case (i_obj_subindex)
					SUB_COUNT: rd_value = {24'h000000, CNT_SPECIAL_MODE};
					SUB_1: begin
						rd_value = {24'h000000, sdm_cfg_reg};
						writable = i_obj_wdata <= 32'(SDM_VIRTUAL);
					end
					SUB_2: begin
						rd_value = {24'h000000, sdm_virt_reg};
						writable = i_obj_wdata[31:8] == 24'h000000;
					end
					default: hit = 1'b0;
				endcase
			end
			IDX_FACTORY: begin
				if (i_obj_subindex == SUB_COUNT) rd_value = {24'h000000, CNT_FACTORY};
				else if (i_obj_subindex == SUB_1) rd_value = {31'h0, i_autosetup_done}; // R4
				else hit = 1'b0;
			end
			IDX_BALLAST: begin
				unique case (i_obj_subindex)
					SUB_COUNT: rd_value = {24'h000000, CNT_BALLAST};
					SUB_1: rd_value = bal_set_reg;
					SUB_2: rd_value = bal_lim_reg;
					SUB_3: rd_value = bal_hyst_reg;
					default: hit = 1'b0;
				endcase
				writable = hit && (i_obj_subindex != SUB_COUNT);
			end
			IDX_SERIAL: begin
				if (i_obj_subindex == SUB_COUNT) rd_value = i_serial_text;
				else hit = 1'b0;
			end
			IDX_DEVICE_IDENTIFIER: begin
				if (i_obj_subindex == SUB_COUNT) rd_value = i_device_identifier;
				else hit = 1'b0;
			end
			IDX_BOOT_INFO: begin
				unique case (i_obj_subindex)
					SUB_COUNT: rd_value = {24'h000000, CNT_BOOT_INFO};
					SUB_1: rd_value = {i_boot_major, i_boot_minor}; // R11
					SUB_2: rd_value = i_boot_fieldbus;
					SUB_3: rd_value = i_boot_hw_group;
					default: hit = 1'b0;
				endcase
			end
			default: hit = 1'b0;
		endcase
	end

	// ========================================
	// register next values
	always_comb begin
		hw_cfg_next = hw_cfg_reg;
		sdm_cfg_next = sdm_cfg_reg;
		sdm_virt_next = sdm_virt_reg;
		bal_set_next = bal_set_reg;
		bal_lim_next = bal_lim_reg;
		bal_hyst_next = bal_hyst_reg;
		ack_next = i_obj_req;
		err_next = i_obj_req && (!hit || (i_obj_write && !writable));
		rdata_next = (i_obj_req && hit && !i_obj_write) ? rd_value : 32'h00000000;
		if (i_obj_req && i_obj_write && hit && writable) begin
			unique case (i_obj_index)
				IDX_HW_CONFIG: hw_cfg_next = i_obj_wdata;
				IDX_SPECIAL_MODE: begin
					if (i_obj_subindex == SUB_1) sdm_cfg_next = i_obj_wdata[7:0];
					else sdm_virt_next = i_obj_wdata[7:0];
				end
				IDX_BALLAST: begin
					if (i_obj_subindex == SUB_1) bal_set_next = i_obj_wdata; // R5
					else if (i_obj_subindex == SUB_2) bal_lim_next = i_obj_wdata; // R6
					else bal_hyst_next = i_obj_wdata; // R7
				end
				default: hw_cfg_next = hw_cfg_reg;
			endcase
		end
		spen_next = sdm_cfg_reg != SDM_OFF; // R1
		spmode_next = 8'h00; // R1
		if (sdm_cfg_reg == SDM_SWITCHES) spmode_next = i_config_switches; // R2
		else if (sdm_cfg_reg == SDM_VIRTUAL) spmode_next = sdm_virt_reg; // R3
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			hw_cfg_reg <= HW_CONFIG_RESET;
			sdm_cfg_reg <= SDM_CFG_RESET;
			sdm_virt_reg <= SDM_VIRT_RESET;
			bal_set_reg <= BAL_SETTINGS_RESET; // R5
			bal_lim_reg <= BAL_LIMIT_RESET;
			bal_hyst_reg <= BAL_HYST_RESET; // R7
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			spen_reg <= 1'b0;
			spmode_reg <= 8'h00;
		end else begin
			hw_cfg_reg <= hw_cfg_next;
			sdm_cfg_reg <= sdm_cfg_next;
			sdm_virt_reg <= sdm_virt_next;
			bal_set_reg <= bal_set_next;
			bal_lim_reg <= bal_lim_next;
			bal_hyst_reg <= bal_hyst_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
			spen_reg <= spen_next;
			spmode_reg <= spmode_next;
		end
	end

	// ========================================
	// ballast control
	ballast_switch ballast_switch_inst (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(bal_set_reg[BAL_ON_BIT]),
		.i_supply_mv(i_power_supply_voltage),
		.i_limit_mv(bal_lim_reg),
		.i_hyst_mv(bal_hyst_reg),
		.o_active(o_ballast_on)
	);

	assign o_obj_ack = ack_reg;
	assign o_obj_error = err_reg;
	assign o_obj_rdata = rdata_reg;
	assign o_special_enable = spen_reg;
	assign o_special_mode = spmode_reg;
	assign o_hw_config = hw_cfg_reg;

	// ========================================
	// checks
	sequence s_read(logic [15:0] idx, logic [7:0] sub);
		i_obj_req && !i_obj_write && i_obj_index == idx && i_obj_subindex == sub;
	endsequence
	a_sdm_off: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
		sdm_cfg_reg == SDM_OFF |=> !o_special_enable && o_special_mode == 8'h00)
		else $error("special modes not off");
	a_sdm_switches: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
		sdm_cfg_reg == SDM_SWITCHES |=> o_special_enable
		&& o_special_mode == $past(i_config_switches))
		else $error("special mode not from switches");
	a_sdm_virtual: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
		sdm_cfg_reg == SDM_VIRTUAL |=> o_special_enable && o_special_mode == $past(sdm_virt_reg))
		else $error("special mode not from virtual switch");
	a_factory_flag_ro: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
		s_read(IDX_FACTORY, SUB_1) |=> o_obj_ack && !o_obj_error
		&& o_obj_rdata == {31'h0, $past(i_autosetup_done)})
		else $error("factory flag read wrong");
	a_factory_write_refused: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
		i_obj_req && i_obj_write && i_obj_index == IDX_FACTORY |=> o_obj_error)
		else $error("factory flag write accepted");
	a_ballast_reset_val: assert property (@(posedge i_clock) // R5
		!i_rst_n |=> bal_set_reg == BAL_SETTINGS_RESET && bal_hyst_reg == BAL_HYST_RESET)
		else $error("ballast reset values wrong");
	a_supply_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R8
		s_read(IDX_OPER_COND, SUB_1) |=> o_obj_rdata == $past(i_power_supply_voltage))
		else $error("supply voltage read wrong");
	a_logic_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R9
		s_read(IDX_OPER_COND, SUB_2) |=> o_obj_rdata == $past(i_logic_supply_voltage))
		else $error("logic voltage read wrong");
	a_temp_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R10
		s_read(IDX_OPER_COND, SUB_3) |=> o_obj_rdata == $past(i_board_temperature))
		else $error("board temperature read wrong");
	a_boot_version: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R11
		s_read(IDX_BOOT_INFO, SUB_1) |=> o_obj_rdata[31:16] == $past(i_boot_major)
		&& o_obj_rdata[15:0] == $past(i_boot_minor))
		else $error("bootloader version layout wrong");
	a_limit_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R6
		i_obj_req && i_obj_write && i_obj_index == IDX_BALLAST && i_obj_subindex == SUB_2
		|=> bal_lim_reg == $past(i_obj_wdata) && o_obj_ack && !o_obj_error)
		else $error("ballast limit write lost");
	c_write_virtual: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		sdm_cfg_reg == SDM_VIRTUAL ##1 o_special_enable);
	c_unmapped: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_obj_error);
	c_ballast_on: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_ballast_on));
endmodule

// [tb/object_host_model.sv]
// host model that drives the object access port
`timescale 1ns/1ps
module object_host_model (
	input wire logic i_clock,
	output logic o_obj_req,
	output logic o_obj_write,
	output logic [15:0] o_obj_index,
	output logic [7:0] o_obj_subindex,
	output logic [31:0] o_obj_wdata,
	input wire logic i_obj_ack,
	input wire logic i_obj_error,
	input wire logic [31:0] i_obj_rdata
);
	// ========================================
	// idle levels
	initial begin
		o_obj_req = 1'b0;
		o_obj_write = 1'b0;
		o_obj_index = 16'h0000;
		o_obj_subindex = 8'h00;
		o_obj_wdata = 32'h00000000;
	end
	// ========================================
	// one access, answer taken one edge after the request
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, output logic [31:0] rd, output logic err, output logic ack);
		@(posedge i_clock);
		o_obj_req <= 1'b1;
		o_obj_write <= wr;
		o_obj_index <= idx;
		o_obj_subindex <= sub;
		o_obj_wdata <= wd;
		@(posedge i_clock);
		o_obj_req <= 1'b0;
		o_obj_wdata <= ~wd;
		#1;
		rd = i_obj_rdata;
		err = i_obj_error;
		ack = i_obj_ack;
	endtask
endmodule

// [tb/drive_parameter_objects_tb_top.sv]
// testbench for the drive parameter object bank
`timescale 1ns/1ps
module drive_parameter_objects_tb_top;
	import drive_param_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic req, wr, ack, err, i_autosetup_done, o_special_enable, o_ballast_on;
	logic [15:0] idx, i_boot_major, i_boot_minor;
	logic [7:0] sub, i_config_switches, o_special_mode;
	logic [31:0] wd, rdata, i_serial_text, i_device_identifier, i_boot_fieldbus;
	logic [31:0] i_boot_hw_group, o_hw_config;
	logic signed [31:0] i_power_supply_voltage, i_logic_supply_voltage, i_board_temperature;
	int fails = 0;
	int cmp_count = 0;
	logic [15:0] cnt_idx [6] = '{IDX_HW_CONFIG, IDX_OPER_COND, IDX_SPECIAL_MODE, IDX_FACTORY,
		IDX_BALLAST, IDX_BOOT_INFO};
	logic [7:0] cnt_val [6] = '{CNT_HW_CONFIG, CNT_OPER_COND, CNT_SPECIAL_MODE, CNT_FACTORY,
		CNT_BALLAST, CNT_BOOT_INFO};
	logic [31:0] sup [8] = '{32'h000003E8, 32'h000003E9, 32'h000003B6, 32'h00000384,
		32'h00000383, 32'h000003B6, 32'h000005DC, 32'hFFFFFB2E};
	logic sup_on [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	always #12.5 i_clock = ~i_clock;
	// ========================================
	// instances
	object_host_model object_host_model_inst (.i_clock(i_clock), .o_obj_req(req),
		.o_obj_write(wr), .o_obj_index(idx), .o_obj_subindex(sub), .o_obj_wdata(wd),
		.i_obj_ack(ack), .i_obj_error(err), .i_obj_rdata(rdata));
	drive_parameter_objects drive_parameter_objects_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_obj_req(req), .i_obj_write(wr), .i_obj_index(idx), .i_obj_subindex(sub),
		.i_obj_wdata(wd), .o_obj_ack(ack), .o_obj_error(err), .o_obj_rdata(rdata),
		.i_power_supply_voltage(i_power_supply_voltage),
		.i_logic_supply_voltage(i_logic_supply_voltage),
		.i_board_temperature(i_board_temperature), .i_config_switches(i_config_switches),
		.i_autosetup_done(i_autosetup_done), .i_serial_text(i_serial_text),
		.i_device_identifier(i_device_identifier), .i_boot_major(i_boot_major),
		.i_boot_minor(i_boot_minor), .i_boot_fieldbus(i_boot_fieldbus),
		.i_boot_hw_group(i_boot_hw_group), .o_special_enable(o_special_enable),
		.o_special_mode(o_special_mode), .o_hw_config(o_hw_config), .o_ballast_on(o_ballast_on));
	// ========================================
	// compare and access tasks
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic exp_err, input logic [31:0] exp_rd);
		logic [31:0] r;
		logic e;
		logic a;
		object_host_model_inst.access(w, i, s, d, r, e, a);
		check_bit(a, 1'b1);
		check_bit(e, exp_err);
		check_word(r, exp_rd);
	endtask
	task automatic give_verdict;
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ========================================
	// watchdog
	initial begin
		#(25 * 3000);
		fails++;
		give_verdict();
	end
	// ========================================
	// tests
	initial begin
		i_power_supply_voltage = 32'hFFFFFB2E;
		i_logic_supply_voltage = 32'h00005DC0;
		i_board_temperature = 32'hFFFFFFC9;
		i_config_switches = 8'h3C;
		i_autosetup_done = 1'b0;
		i_serial_text = 32'h12345678;
		i_device_identifier = 32'h0BADF00D;
		i_boot_major = 16'h0004;
		i_boot_minor = 16'h0002;
		i_boot_fieldbus = 32'h00000011;
		i_boot_hw_group = 32'h00000022;
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		xfer(1'b0, IDX_SPECIAL_MODE, SUB_1, 32'h0, 1'b0, 32'h01);
		xfer(1'b0, IDX_SPECIAL_MODE, SUB_2, 32'h0, 1'b0, 32'h00);
		xfer(1'b0, IDX_BALLAST, SUB_1, 32'h0, 1'b0, 32'h00000001);
		xfer(1'b0, IDX_BALLAST, SUB_2, 32'h0, 1'b0, 32'h0000D867);
		xfer(1'b0, IDX_BALLAST, SUB_3, 32'h0, 1'b0, 32'h000001F4);
		for (int k = 0; k < 6; k++) begin
			xfer(1'b0, cnt_idx[k], SUB_COUNT, 32'h0, 1'b0, {24'h0, cnt_val[k]});
		end
		xfer(1'b0, IDX_OPER_COND, SUB_1, 32'h0, 1'b0, 32'hFFFFFB2E);
		xfer(1'b0, IDX_OPER_COND, SUB_2, 32'h0, 1'b0, 32'h00005DC0);
		xfer(1'b0, IDX_OPER_COND, SUB_3, 32'h0, 1'b0, 32'hFFFFFFC9);
		xfer(1'b0, IDX_OPER_COND, SUB_4, 32'h0, 1'b0, 32'h0);
		xfer(1'b1, IDX_OPER_COND, SUB_1, 32'h5, 1'b1, 32'h0);
		xfer(1'b0, IDX_FACTORY, SUB_1, 32'h0, 1'b0, 32'h0);
		i_autosetup_done <= 1'b1;
		xfer(1'b0, IDX_FACTORY, SUB_1, 32'h0, 1'b0, 32'h1);
		xfer(1'b1, IDX_FACTORY, SUB_1, 32'h0, 1'b1, 32'h0);
		xfer(1'b0, IDX_BOOT_INFO, SUB_1, 32'h0, 1'b0, 32'h00040002);
		xfer(1'b0, IDX_BOOT_INFO, SUB_3, 32'h0, 1'b0, 32'h00000022);
		xfer(1'b0, IDX_SERIAL, SUB_COUNT, 32'h0, 1'b0, 32'h12345678);
		xfer(1'b0, IDX_DEVICE_IDENTIFIER, SUB_COUNT, 32'h0, 1'b0, 32'h0BADF00D);
		xfer(1'b0, IDX_BOOT_INFO, SUB_2, 32'h0, 1'b0, 32'h00000011);
		xfer(1'b0, 16'h4017, SUB_1, 32'h0, 1'b1, 32'h0);
		xfer(1'b0, IDX_BALLAST, 8'h04, 32'h0, 1'b1, 32'h0);
		xfer(1'b1, IDX_HW_CONFIG, SUB_1, 32'hA5A50001, 1'b0, 32'h0);
		xfer(1'b0, IDX_HW_CONFIG, SUB_1, 32'h0, 1'b0, 32'hA5A50001);
		check_word(o_hw_config, 32'hA5A50001);
		xfer(1'b1, IDX_SPECIAL_MODE, SUB_2, 32'h5, 1'b0, 32'h0);
		xfer(1'b1, IDX_SPECIAL_MODE, SUB_2, 32'h100, 1'b1, 32'h0);
		for (int c = 0; c < 3; c++) begin
			xfer(1'b1, IDX_SPECIAL_MODE, SUB_1, 32'(c), 1'b0, 32'h0);
			repeat (3) @(posedge i_clock);
			check_bit(o_special_enable, c != 0);
			check_word({24'h0, o_special_mode}, c == 0 ? 32'h0 : c == 1 ? 32'h3C : 32'h5);
		end
		xfer(1'b1, IDX_SPECIAL_MODE, SUB_1, 32'h3, 1'b1, 32'h0);
		xfer(1'b1, IDX_SPECIAL_MODE, SUB_1, 32'h1, 1'b0, 32'h0);
		i_config_switches <= 8'hC3;
		repeat (3) @(posedge i_clock);
		check_word({24'h0, o_special_mode}, 32'hC3);
		xfer(1'b1, IDX_BALLAST, SUB_2, 32'h000003E8, 1'b0, 32'h0);
		xfer(1'b1, IDX_BALLAST, SUB_3, 32'h00000064, 1'b0, 32'h0);
		for (int k = 0; k < 8; k++) begin
			i_power_supply_voltage <= sup[k];
			repeat (3) @(posedge i_clock);
			check_bit(o_ballast_on, sup_on[k]);
		end
		i_power_supply_voltage <= 32'h000005DC;
		xfer(1'b1, IDX_BALLAST, SUB_1, 32'h0, 1'b0, 32'h0);
		repeat (3) @(posedge i_clock);
		check_bit(o_ballast_on, 1'b0);
		xfer(1'b1, IDX_BALLAST, SUB_1, 32'h1, 1'b0, 32'h0);
		repeat (3) @(posedge i_clock);
		check_bit(o_ballast_on, 1'b1);
		// ========================================
		// mid-run reset restores presets
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		xfer(1'b0, IDX_BALLAST, SUB_2, 32'h0, 1'b0, 32'h0000D867);
		xfer(1'b0, IDX_BALLAST, SUB_3, 32'h0, 1'b0, 32'h000001F4);
		xfer(1'b0, IDX_SPECIAL_MODE, SUB_2, 32'h0, 1'b0, 32'h00);
		check_bit(o_ballast_on, 1'b0);
		check_word(o_hw_config, 32'h00000000);
		give_verdict();
	end
endmodule
